// ### hw/adc_spi_cmd.sv
// SPI frame command decoder, response path and buffered output data path
`timescale 1ns/10ps
module adc_spi_cmd #(
  parameter int          RAW_W    = 32,
  parameter int          NUM_REGS = 16,
  parameter logic [15:0] ID_VALUE = 16'hA501 // Arbitrary identity value
) (
  input  wire logic                                     core_clk_in,
  input  wire logic                                     reset_n_in,
  input  wire logic                                     sample_valid_in,
  input  wire logic [adc_cmd_pkg::NUM_CH*RAW_W-1:0]     sample_raw_in,
  input  wire logic                                     sync_reset_n_in,
  input  wire logic                                     sclk_in,
  input  wire logic                                     cs_n_in,
  input  wire logic                                     din_in,
  output logic                                          dout_out,
  output logic                                          sample_ready_indicator_n_out,
  output logic                                          standby_out,
  output logic                                          locked_out,
  output logic                                          resync_out
);
  localparam int NCH  = adc_cmd_pkg::NUM_CH;
  localparam int W    = adc_cmd_pkg::WORD_W;
  localparam int CW   = adc_cmd_pkg::CODE_W;
  localparam int RI_W = $clog2(NUM_REGS);
  localparam logic [W-adc_cmd_pkg::PAY_W-1:0] PAD = '0;

  // Core-domain state
  logic                  cs_meta, cs_s, cs_d;
  logic                  sr_meta, sr_s, sr_d;
  logic                  tg_meta, tg_s, tg_d;
  logic [15:0]           regs [NUM_REGS];
  logic [15:0]           cmd_word;
  logic                  cmd_valid;
  logic [15:0]           resp_word;
  logic                  rd_multi;
  logic [7:0]            rd_addr;
  logic [6:0]            rd_cnt;
  logic                  locked, standby;
  logic                  wr_active;
  logic [7:0]            wr_ptr, wr_left, wr_done;
  logic                  data_taken, pend, refill, ind_n;
  logic [3:0]            pulse_cnt;
  logic [CW-1:0]         ch_out [NCH];
  logic [CW-1:0]         code [NCH];
  logic [CW-1:0]         head [NCH];
  logic [1:0]            cnt [NCH];
  logic [NCH-1:0]        sample_ready_indicator, left_after;
  logic [15:0]           status_word;
  logic                  frame_start, frame_end, word_evt, sync_fall, push_evt;
  logic                  do_default;
  adc_cmd_pkg::cmd_t     fe_cmd;

  // Link-domain state
  logic                  active;
  logic [4:0]            bit_pos, next_bit_pos;
  logic [7:0]            word_no, next_word_no;
  logic [W-1:0]          rx_shift, rx_next, tx_cur;
  logic [15:0]           rx_word;
  logic [7:0]            rx_idx;
  logic                  rx_toggle, frame_full;

  // Register view shared by the response path and the link read-out
  function automatic logic [15:0] reg_value(input logic [7:0] idx);
    if (idx == 8'(adc_cmd_pkg::REG_ID_IDX)) return ID_VALUE;
    else if (idx == 8'(adc_cmd_pkg::REG_STATUS_IDX)) return status_word;
    else if (idx < 8'(NUM_REGS)) return regs[RI_W'(idx)];
    else return 16'h0000;
  endfunction

  // Only configuration registers accept writes; ID, status and gaps do not
  function automatic logic writable(input logic [7:0] idx);
    return idx > 8'(adc_cmd_pkg::REG_STATUS_IDX) && idx < 8'(NUM_REGS);
  endfunction

  // Word shifted out at position n of the current frame
  function automatic logic [W-1:0] tx_word(input logic [7:0] n);
    logic [W-1:0] t;
    t = '0;
    if (n == 8'h00) t = {resp_word, PAD};                      // see [RULE10]
    else if (rd_multi) begin
      if ({1'b0, n} <= {2'b00, rd_cnt} + 9'h001)
        t = {reg_value(rd_addr + n - 8'h01), PAD};             // see [RULE21]
    end else if (n <= 8'(NCH)) t = ch_out[3'(n - 8'h01)];      // see [RULE19]
    return t;
  endfunction

  // ---------------- Link domain: runs on SPI clock edges and select edges ----------------

  // Frame-active flag, cleared by the frame's own select going high
  always_ff @(posedge sclk_in or posedge cs_n_in or negedge reset_n_in) begin
    if (!reset_n_in) active <= 1'b0;
    else if (cs_n_in) active <= 1'b0;
    else active <= 1'b1;
  end

  // Position of the bit about to be shifted; word count saturates
  always_comb begin
    if (!active) begin
      next_bit_pos = 5'h00;
      next_word_no = 8'h00;
    end else if (bit_pos == 5'(W-1)) begin
      next_bit_pos = 5'h00;
      next_word_no = (word_no == 8'hFF) ? word_no : word_no + 8'h01;
    end else begin
      next_bit_pos = bit_pos + 5'h01;
      next_word_no = word_no;
    end
    tx_cur = tx_word(next_word_no);
  end

  // Device launches on the rising edge, host samples on the falling edge
  always_ff @(posedge sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_pos  <= 5'h00;
      word_no  <= 8'h00;
      dout_out <= 1'b0;
    end else begin
      bit_pos  <= next_bit_pos;
      word_no  <= next_word_no;
      dout_out <= tx_cur[5'(W-1) - next_bit_pos];              // see [RULE23]
    end
  end

  assign rx_next = {rx_shift[W-2:0], din_in};

  // Input words are caught on the falling edge; each full word flips a toggle
  always_ff @(negedge sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_shift   <= '0;
      rx_word    <= 16'h0000;
      rx_idx     <= 8'h00;
      rx_toggle  <= 1'b0;
      frame_full <= 1'b0;
    end else begin
      rx_shift <= rx_next;
      if (bit_pos == 5'h00 && word_no == 8'h00) frame_full <= 1'b0;
      if (bit_pos == 5'(W-1)) begin
        rx_word   <= rx_next[W-1 -: 16];                       // see [RULE23]
        rx_idx    <= word_no;
        rx_toggle <= ~rx_toggle;
        if (word_no == 8'(adc_cmd_pkg::FRAME_WORDS-1)) frame_full <= 1'b1;
      end
    end
  end

  // ---------------- Core domain ----------------

  // Two-flop synchronisers; the third flop only serves edge detection
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {cs_meta, cs_s, cs_d} <= 3'h7;
      {sr_meta, sr_s, sr_d} <= 3'h7;
      {tg_meta, tg_s, tg_d} <= 3'h0;
    end else begin
      {cs_meta, cs_s, cs_d} <= {cs_n_in, cs_meta, cs_s};
      {sr_meta, sr_s, sr_d} <= {sync_reset_n_in, sr_meta, sr_s};
      {tg_meta, tg_s, tg_d} <= {rx_toggle, tg_meta, tg_s};
    end
  end

  assign frame_start = cs_d & ~cs_s;
  assign frame_end   = ~cs_d & cs_s;
  assign word_evt    = tg_s ^ tg_d;
  assign sync_fall   = sr_d & ~sr_s;
  assign push_evt    = sample_valid_in & ~standby;

  // Per-channel coding and two-slot buffering; readout pops at frame start
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    sample_coder #(.RAW_W(RAW_W)) u_coder (
      .raw_in   (sample_raw_in[ch*RAW_W +: RAW_W]),
      .code_out (code[ch])
    );
    channel_fifo #(.DATA_W(CW)) u_fifo (
      .clk_in       (core_clk_in),
      .reset_n_in   (reset_n_in),
      .flush_in     (sync_fall),                               // see [RULE6]
      .push_in      (push_evt),
      .push_data_in (code[ch]),
      .pop_in       (frame_start & ~rd_multi),                 // see [RULE5]
      .head_out     (head[ch]),
      .count_out    (cnt[ch])
    );
    assign sample_ready_indicator[ch]       = cnt[ch] != 2'h0;                   // see [RULE4]
    assign left_after[ch] = cnt[ch] != 2'h0;
  end

  // Output data words are held steady for the whole frame
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NCH; i++) ch_out[i] <= '0;
    end else if (frame_start && !rd_multi) begin
      for (int i = 0; i < NCH; i++) ch_out[i] <= sample_ready_indicator[i] ? head[i] : ch_out[i];
    end
  end

  // Status word: ready flags plus lock and standby state
  always_comb begin
    status_word = 16'h0000;
    status_word[NCH-1:0] = sample_ready_indicator;
    status_word[adc_cmd_pkg::STATUS_LOCK_BIT] = locked;
    status_word[adc_cmd_pkg::STATUS_STBY_BIT] = standby;
  end

  // Latch the command word and follow register-write data as it arrives
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_word  <= 16'h0000;
      cmd_valid <= 1'b0;
      wr_active <= 1'b0;
      wr_ptr    <= 8'h00;
      wr_left   <= 8'h00;
      wr_done   <= 8'h00;
    end else if (word_evt && rx_idx == 8'h00) begin
      cmd_word  <= rx_word;
      cmd_valid <= 1'b1;
      wr_active <= adc_cmd_pkg::decode_cmd(rx_word) == adc_cmd_pkg::CMD_REGISTER_WRITE_CMD
                   && !locked;                                 // see [RULE24]
      wr_ptr    <= {2'b00, rx_word[12:7]};                     // see [RULE22]
      wr_left   <= {1'b0, rx_word[6:0]} + 8'h01;
      wr_done   <= 8'h00;
    end else if (word_evt && wr_active && wr_left != 8'h00) begin
      wr_ptr  <= wr_ptr + 8'h01;
      wr_left <= wr_left - 8'h01;
      if (writable(wr_ptr)) wr_done <= wr_done + 8'h01;        // see [RULE22]
    end else if (frame_end) begin
      cmd_valid <= 1'b0;
      wr_active <= 1'b0;
    end
  end

  // Registers are written while data shifts in; a reset restores defaults
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NUM_REGS; i++) regs[i] <= adc_cmd_pkg::REG_RESET;
      regs[adc_cmd_pkg::REG_MODE_IDX] <= adc_cmd_pkg::MODE_RESET;
    end else if (do_default) begin
      for (int i = 0; i < NUM_REGS; i++) regs[i] <= adc_cmd_pkg::REG_RESET;
      regs[adc_cmd_pkg::REG_MODE_IDX] <= adc_cmd_pkg::MODE_RESET; // see [RULE13]
    end else if (word_evt && rx_idx != 8'h00 && wr_active && wr_left != 8'h00
                 && writable(wr_ptr)) begin
      regs[RI_W'(wr_ptr)] <= rx_word;
    end
  end

  // While locked, anything but nop, read and unlock acts as invalid
  always_comb begin
    fe_cmd = cmd_valid ? adc_cmd_pkg::decode_cmd(cmd_word) : adc_cmd_pkg::CMD_NULL;
    if (locked && fe_cmd != adc_cmd_pkg::CMD_NULL && fe_cmd != adc_cmd_pkg::CMD_REGISTER_READ_CMD
        && fe_cmd != adc_cmd_pkg::CMD_UNLOCK)
      fe_cmd = adc_cmd_pkg::CMD_INVALID;                       // see [RULE18] [RULE24]
  end

  // Commands other than register writes take effect at frame end; the answer goes out next frame
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resp_word  <= 16'h0000;
      rd_multi   <= 1'b0;
      rd_addr    <= 8'h00;
      rd_cnt     <= 7'h00;
      locked     <= 1'b0;
      standby    <= 1'b0;
      do_default <= 1'b0;
    end else begin
      do_default <= 1'b0;
      if (frame_end) begin
        rd_multi <= 1'b0;
        unique case (fe_cmd)
          adc_cmd_pkg::CMD_NULL,
          adc_cmd_pkg::CMD_INVALID: resp_word <= status_word;  // see [RULE11] [RULE12]
          adc_cmd_pkg::CMD_RESET: begin
            if (frame_full) begin                              // see [RULE13]
              resp_word  <= adc_cmd_pkg::RESP_RESET_ACK;       // see [RULE14]
              do_default <= 1'b1;
              locked     <= 1'b0;
              standby    <= 1'b0;
            end else begin
              resp_word <= adc_cmd_pkg::RESP_RESET_CUT;        // see [RULE14]
            end
          end
          adc_cmd_pkg::CMD_STANDBY: begin
            standby   <= 1'b1;                                 // see [RULE16]
            resp_word <= cmd_word;
          end
          adc_cmd_pkg::CMD_WAKEUP: begin
            standby   <= 1'b0;                                 // see [RULE17]
            resp_word <= cmd_word;
          end
          adc_cmd_pkg::CMD_LOCK: begin
            locked    <= 1'b1;                                 // see [RULE18]
            resp_word <= cmd_word;
          end
          adc_cmd_pkg::CMD_UNLOCK: begin
            locked    <= 1'b0;                                 // see [RULE20]
            resp_word <= cmd_word;
          end
          adc_cmd_pkg::CMD_REGISTER_READ_CMD: begin
            rd_addr <= {2'b00, cmd_word[12:7]};
            rd_cnt  <= cmd_word[6:0];
            if (cmd_word[6:0] == 7'h00) begin
              resp_word <= reg_value({2'b00, cmd_word[12:7]}); // see [RULE21]
            end else begin
              resp_word <= {adc_cmd_pkg::PFX_RD_HDR, cmd_word[12:0]};
              rd_multi  <= 1'b1;                               // see [RULE21]
            end
          end
          adc_cmd_pkg::CMD_REGISTER_WRITE_CMD: begin
            resp_word <= {adc_cmd_pkg::PFX_WR_RESP, cmd_word[12:7],
                          (wr_done == 8'h00) ? 7'h00 : 7'(wr_done - 8'h01)}; // see [RULE22]
          end
        endcase
      end
    end
  end

  // Readout bookkeeping; a second buffered sample re-arms ready one cycle
  // later, which is the narrow high pulse the host must not depend on
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_taken <= 1'b0;
      pend       <= 1'b0;
      refill     <= 1'b0;
    end else begin
      refill <= 1'b0;
      if (frame_start && !rd_multi) data_taken <= 1'b1;
      if (sync_fall) begin
        pend       <= 1'b0;                                    // see [RULE6]
        data_taken <= 1'b0;
      end else if (frame_end && data_taken) begin
        pend       <= push_evt;                                // A set in this cycle wins
        data_taken <= 1'b0;
        refill     <= |left_after;                             // see [RULE8]
      end else if (push_evt || refill) begin
        pend <= 1'b1;
      end
    end
  end

  // Pin driver: level format follows pend, pulse format gives a short low
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_cnt <= 4'h0;
      ind_n     <= 1'b1;
    end else begin
      if (push_evt) pulse_cnt <= 4'(adc_cmd_pkg::PULSE_CYCLES);
      else if (pulse_cnt != 4'h0) pulse_cnt <= pulse_cnt - 4'h1;
      if (regs[adc_cmd_pkg::REG_MODE_IDX][adc_cmd_pkg::MODE_FMT_BIT])
        ind_n <= pulse_cnt == 4'h0;
      else ind_n <= ~pend;                                     // see [RULE8]
    end
  end

  // Sync strobe notice towards the conversion logic
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) resync_out <= 1'b0;
    else resync_out <= sync_fall;                              // see [RULE6]
  end

  assign sample_ready_indicator_n_out = ind_n;
  assign standby_out                  = standby;
  assign locked_out                   = locked;
endmodule

// ### common/adc_cmd_pkg.sv
// Constants, command codes and decode helper for the ADC SPI command block
// Functional notes
// [RULE1] Results 24-bit two's complement, saturating at limits
// [RULE2] Codes around zero follow plain two's complement
// [RULE3] Two sample slots per channel
// [RULE4] Ready flag holds until both slots read
// [RULE5] Each consecutive read empties the buffered sample
// [RULE6] Sync strobe resynchronizes and empties all buffers
// [RULE7] Host syncs or double-reads after a pause
// [RULE8] Level format: narrow high pulse after first readout
// [RULE9] Host must not rely on narrow pulse
// [RULE10] Response appears in next frame's first word
// [RULE11] No-operation changes nothing, returns status
// [RULE12] Invalid command behaves as no-operation
// [RULE13] Reset latched at full frame end, restores defaults
// [RULE14] Reset answers FF28h, cut frame answers 0011h
// [RULE15] Host waits settle time after reset
// [RULE16] Standby latched at frame end, echoes word
// [RULE17] Wakeup leaves standby, echoes word
// [RULE18] Lock echoes, then only nop/read/unlock act
// [RULE19] Conversion data keeps flowing while locked
// [RULE20] Unlock leaves locked state, echoes word
// [RULE21] Register read: single value or header plus values
// [RULE22] Register write answers address and written count
// [RULE23] 16-bit payload MSB aligned, low bits zero
// [RULE24] Locked: other commands ignored, status returned
package adc_cmd_pkg;
  localparam int NUM_CH       = 8;
  localparam int WORD_W       = 24;
  localparam int PAY_W        = 16;
  localparam int CODE_W       = 24;
  localparam int FRAME_WORDS  = 10;
  localparam int ADDR_W       = 6;
  localparam int CNT_W        = 7;
  localparam int PULSE_CYCLES = 4;
  localparam logic [15:0] CMD_NULL_W     = 16'h0000;
  localparam logic [15:0] CMD_RESET_W    = 16'h0011;
  localparam logic [15:0] CMD_STANDBY_W  = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP_W   = 16'h0033;
  localparam logic [15:0] CMD_LOCK_W     = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK_W   = 16'h0655;
  localparam logic [15:0] RESP_RESET_ACK = 16'hFF28;
  localparam logic [15:0] RESP_RESET_CUT = 16'h0011;
  localparam logic [2:0]  PFX_RD         = 3'h5;
  localparam logic [2:0]  PFX_RD_HDR     = 3'h7;
  localparam logic [2:0]  PFX_WR         = 3'h3;
  localparam logic [2:0]  PFX_WR_RESP    = 3'h2;
  localparam logic [CODE_W-1:0] CODE_MAX = 24'h7FFFFF;
  localparam logic [CODE_W-1:0] CODE_MIN = 24'h800000;
  localparam int REG_ID_IDX      = 0;
  localparam int REG_STATUS_IDX  = 1;
  localparam int REG_MODE_IDX    = 2;
  localparam int MODE_FMT_BIT    = 0;
  localparam int STATUS_LOCK_BIT = 15;
  localparam int STATUS_STBY_BIT = 14;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET  = 16'h0000;

  typedef enum logic [3:0] {
    CMD_NULL, CMD_RESET, CMD_STANDBY, CMD_WAKEUP, CMD_LOCK, CMD_UNLOCK,
    CMD_REGISTER_READ_CMD, CMD_REGISTER_WRITE_CMD, CMD_INVALID
  } cmd_t;

  // Map a command word to its kind; anything unknown is invalid
  function automatic cmd_t decode_cmd(input logic [15:0] w);
    cmd_t c;
    c = CMD_INVALID;
    if (w == CMD_NULL_W) c = CMD_NULL;
    else if (w == CMD_RESET_W) c = CMD_RESET;
    else if (w == CMD_STANDBY_W) c = CMD_STANDBY;
    else if (w == CMD_WAKEUP_W) c = CMD_WAKEUP;
    else if (w == CMD_LOCK_W) c = CMD_LOCK;
    else if (w == CMD_UNLOCK_W) c = CMD_UNLOCK;
    else if (w[15:13] == PFX_RD) c = CMD_REGISTER_READ_CMD;
    else if (w[15:13] == PFX_WR) c = CMD_REGISTER_WRITE_CMD;
    return c;
  endfunction
endpackage

// ### hw/sample_coder.sv
// Saturating conversion of a wide signed result to a 24-bit output code
`timescale 1ns/10ps
module sample_coder #(
  parameter int RAW_W = 32
) (
  input  wire logic signed [RAW_W-1:0]                raw_in,
  output logic             [adc_cmd_pkg::CODE_W-1:0]  code_out
);
  localparam int CW = adc_cmd_pkg::CODE_W;
  localparam logic signed [RAW_W-1:0] POS_LIM = {{(RAW_W-CW+1){1'b0}}, {(CW-1){1'b1}}};
  localparam logic signed [RAW_W-1:0] NEG_LIM = {{(RAW_W-CW+1){1'b1}}, {(CW-1){1'b0}}};

  // Clip beyond full scale, pass in-range values unchanged
  always_comb begin
    if (raw_in >= POS_LIM) code_out = adc_cmd_pkg::CODE_MAX;      // see [RULE1]
    else if (raw_in <= NEG_LIM) code_out = adc_cmd_pkg::CODE_MIN; // see [RULE1]
    else code_out = raw_in[CW-1:0];                               // see [RULE2]
  end
endmodule

// ### hw/channel_fifo.sv
// Two-slot sample buffer for one channel, oldest sample at the head
`timescale 1ns/10ps
module channel_fifo #(
  parameter int DATA_W = 24
) (
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              flush_in,
  input  wire logic              push_in,
  input  wire logic [DATA_W-1:0] push_data_in,
  input  wire logic              pop_in,
  output logic      [DATA_W-1:0] head_out,
  output logic      [1:0]        count_out
);
  logic [DATA_W-1:0] slot [2];
  logic [1:0]        count;

  // A push into a full buffer drops the oldest sample so the newest is kept
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count   <= 2'h0;
      slot[0] <= '0;
      slot[1] <= '0;
    end else if (flush_in) begin
      count <= 2'h0;
    end else if (push_in && (pop_in || count == 2'h2) && count != 2'h0) begin
      slot[0] <= (count == 2'h1) ? push_data_in : slot[1]; // see [RULE3]
      slot[1] <= push_data_in;
    end else if (push_in) begin
      slot[count[0]] <= push_data_in;
      count          <= count + 2'h1;
    end else if (pop_in && count != 2'h0) begin
      slot[0] <= slot[1];
      count   <= count - 2'h1;                             // see [RULE5]
    end
  end

  assign head_out  = slot[0];
  assign count_out = count;
endmodule

// ### testbench/adc_spi_cmd_assertions.sv
// Port-level checks for the SPI command block, bound into its top module
`timescale 1ns/10ps
module adc_spi_cmd_checker (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic sample_valid_in,
  input wire logic sync_reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic dout_out,
  input wire logic sample_ready_indicator_n_out,
  input wire logic standby_out,
  input wire logic locked_out,
  input wire logic resync_out
);
  logic [9:0] bit_cnt;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Rising sclk count inside a frame; cs_n high restarts it between frames
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) bit_cnt <= 10'h000;
    else bit_cnt <= bit_cnt + 10'h001;
  end
  resync_due_a: assert property ($fell(sync_reset_n_in) |-> ##[1:4] resync_out)
    else $error("no resync pulse after sync strobe");
  resync_one_a: assert property (resync_out |=> !resync_out)
    else $error("resync pulse longer than one cycle");
  resync_src_a: assert property (resync_out |-> !$past(sync_reset_n_in, 2))
    else $error("resync pulse without sync strobe");
  ready_push_a: assert property (sample_valid_in && !standby_out && cs_n_in
    |-> ##[1:2] !sample_ready_indicator_n_out) else $error("ready pin missed new data");
  flush_clear_a: assert property (resync_out
    |-> ##[0:1] sample_ready_indicator_n_out) else $error("ready pin still low after flush");
  lock_hold_a: assert property (!cs_n_in [*4] |=> $stable(locked_out))
    else $error("lock state changed inside a frame");
  stby_hold_a: assert property (!cs_n_in [*4] |=> $stable(standby_out))
    else $error("standby changed inside a frame");
  resp_pad_a: assert property (@(posedge sclk_in)
    disable iff (!reset_n_in || cs_n_in)
    bit_cnt >= 10'h011 && bit_cnt <= 10'h018 |-> !dout_out) else $error("response pad not zero");
  cover property ($rose(locked_out));
  cover property ($rose(standby_out));
  cover property (resync_out);
endmodule
bind adc_spi_cmd adc_spi_cmd_checker i_adc_spi_cmd_checker (.core_clk_in, .reset_n_in,
  .sample_valid_in, .sync_reset_n_in, .sclk_in, .cs_n_in, .dout_out,
  .sample_ready_indicator_n_out, .standby_out, .locked_out, .resync_out);

// ### testbench/spi_host_model.sv
// Host controller model: shifts whole 24-bit words, clock only inside frames
`timescale 1ns/10ps
module spi_host_model (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out,
  input  wire logic dout_in
);
  logic [23:0] tx_words [0:15];
  logic [23:0] rx_words [0:15];
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b0;
    foreach (tx_words[i]) tx_words[i] = 24'h000000;
  end
  // Bits go MSB first; din turns to the inverse after the frame so no stale value lingers
  task automatic frame(input int nwords);
    #13 cs_n_out = 1'b0;
    for (int i = 0; i < nwords * 24; i++) begin
      #40 sclk_out = 1'b1;
      din_out = tx_words[i / 24][23 - i % 24];
      #40 rx_words[i / 24][23 - i % 24] = dout_in;
      sclk_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    din_out = ~din_out;
  endtask
endmodule

// ### testbench/tb.sv
// Self-checking bench for the SPI command block with a host model
`timescale 1ns/10ps
module tb;
  logic        clk, rst_n, valid, sync_n, sclk, cs_n, din, dout, rdy_n, stby, lck, rsy;
  logic [255:0] raw;
  int          num_errors, checks_done;
  logic [23:0] exp_code [0:6] = '{24'h7FFFFF, 24'h7FFFFF, 24'h000001, 24'h000000,
                                  24'hFFFFFF, 24'h800000, 24'h800000};
  adc_spi_cmd i_adc_spi_cmd (.core_clk_in(clk), .reset_n_in(rst_n), .sample_valid_in(valid),
    .sample_raw_in(raw), .sync_reset_n_in(sync_n), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .dout_out(dout), .sample_ready_indicator_n_out(rdy_n),
    .standby_out(stby), .locked_out(lck), .resync_out(rsy));
  spi_host_model i_spi_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
    .dout_in(dout));
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [23:0] rx(input int k);
    return i_spi_host_model.rx_words[k];
  endfunction
  // New conversion set; channel 7 carries a tag so samples can be told apart
  task automatic push(input logic [23:0] v);
    @(negedge clk);
    raw[255:224] = {8'h00, v};
    valid = 1'b1;
    @(negedge clk) valid = 1'b0;
  endtask
  // One frame; the gap after it covers the crossing back to the core
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] d1, input int n);
    i_spi_host_model.tx_words[0] = {cmd, 8'h00};
    i_spi_host_model.tx_words[1] = {d1, 8'h00};
    i_spi_host_model.frame(n);
    #100;
  endtask
  task automatic t_coding();
    push(24'h000007);
    repeat (2) @(negedge clk);
    check({23'h0, rdy_n}, 24'h000000);
    xfer(16'h0000, 16'h0000, 10);
    for (int i = 0; i < 7; i++) check(rx(i + 1), exp_code[i]);
    $display("coding test done");
  endtask
  task automatic t_nop();
    push(24'h000011);
    xfer(16'h0000, 16'h0000, 10);
    push(24'h000012);
    xfer(16'h1234, 16'h0000, 10);
    check(rx(0), 24'h000000);
    xfer(16'h0000, 16'h0000, 10);
    check(rx(0), 24'h000000);
    check(rx(8), 24'h000012);
    $display("no-op test done");
  endtask
  // Two unread sets, then read back to back as after a pause
  task automatic t_fifo();
    push(24'h000021);
    push(24'h000022);
    xfer(16'h0000, 16'h0000, 10);
    check(rx(8), 24'h000021);
    check({23'h0, rdy_n}, 24'h000000);
    xfer(16'h0000, 16'h0000, 10);
    check(rx(0), 24'h00FF00);
    check(rx(8), 24'h000022);
    $display("buffer test done");
  endtask
  task automatic t_sync();
    push(24'h000031);
    @(negedge clk) sync_n = 1'b0;
    repeat (3) @(negedge clk);
    check({23'h0, rsy}, 24'h000001);
    repeat (5) @(negedge clk);
    sync_n = 1'b1;
    repeat (4) @(negedge clk);
    check({23'h0, rdy_n}, 24'h000001);
    $display("sync test done");
  endtask
  // Mode commands chained; each answer comes one frame later
  task automatic t_cmds();
    logic [15:0] cmd [0:5] = '{16'h0022, 16'h0033, 16'h0555, 16'h0022, 16'h0655, 16'h0000};
    logic [15:0] rsp [0:4] = '{16'h0022, 16'h0033, 16'h0555, 16'h8000, 16'h0655};
    logic [1:0]  st [0:4] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h0};
    for (int i = 0; i < 6; i++) begin
      if (i == 3) push(24'h000041);
      xfer(cmd[i], 16'h0000, 10);
      if (i > 0) check(rx(0), {rsp[i-1], 8'h00});
      if (i < 5) check({22'h0, lck, stby}, {22'h0, st[i]});
      if (i == 3) check(rx(8), 24'h000041);
    end
    $display("command test done");
  endtask
  // Write mode, read back single and multiple, then cut and full resets
  task automatic t_regs();
    xfer(16'h6100, 16'h0001, 10);
    xfer(16'hA100, 16'h0000, 10);
    check(rx(0), 24'h410000);
    push(24'h000051);
    repeat (6) @(negedge clk);
    check({23'h0, rdy_n}, 24'h000001);
    xfer(16'hA001, 16'h0000, 10);
    check(rx(0), 24'h000100);
    xfer(16'h0011, 16'h0000, 2);
    check(rx(0), 24'hE00100);
    check(rx(1), 24'hA50100);
    xfer(16'h0011, 16'h0000, 10);
    check(rx(0), 24'h001100);
    #2000;
    xfer(16'hA100, 16'h0000, 10);
    check(rx(0), 24'hFF2800);
    xfer(16'h0000, 16'h0000, 10);
    check(rx(0), 24'h000000);
    $display("register test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    valid = 1'b0;
    sync_n = 1'b1;
    num_errors = 0;
    checks_done = 0;
    raw = {32'h0000_0000, 32'h8000_0000, 32'hFF80_0000, 32'hFFFF_FFFF, 32'h0000_0000,
           32'h0000_0001, 32'h007F_FFFF, 32'h7FFF_FFFF};
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_coding();
    t_nop();
    t_fifo();
    t_sync();
    t_cmds();
    t_regs();
    tally_and_finish();
  end
  // Watchdog against a hung run
  initial begin
    #900000;
    num_errors++;
    tally_and_finish();
  end
endmodule
